// File: src/vfsc_pkg.sv
package vfsc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ACTSEL  = 8'h04;
  localparam logic [7:0] ADDR_TOTAL   = 8'h08;
  localparam logic [7:0] ADDR_LIMIT   = 8'h0c;
  localparam logic [7:0] ADDR_CLEAR   = 8'h10;
  localparam logic [7:0] ADDR_DIAG    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_INTSTAT = 8'h1c;
  localparam logic [7:0] ADDR_INTMASK = 8'h20;

  // Control register fields
  localparam int CTRL_OOS       = 0;
  localparam int CTRL_DIAG_AUTO = 1;
  localparam int CTRL_FORCE     = 2;
  localparam int CTRL_CHAN_USED = 3;
  localparam int CTRL_AUX_INPUT_ONE_ROUTE = 4;
  localparam int CTRL_AUX_INPUT_TWO_ROUTE = 5;
  localparam int CTRL_WIDTH     = 6;
  localparam logic [5:0] CTRL_RST = 6'h0a;

  // Action select fields, two bits each
  localparam int SEL_FAULT  = 0;
  localparam int SEL_OOS    = 2;
  localparam int SEL_PRESET = 4;
  localparam logic [5:0] ACTSEL_RST = 6'h00;

  // Action encodings and valve positions
  localparam logic [1:0] ACT_HOLD   = 2'h0;
  localparam logic [1:0] ACT_CLOSE  = 2'h1;
  localparam logic [1:0] ACT_OPEN   = 2'h2;
  localparam logic [1:0] ACT_PRESET = 2'h3;
  localparam logic [1:0] POS_CLOSE  = 2'h0;
  localparam logic [1:0] POS_OPEN   = 2'h1;
  localparam logic [1:0] POS_STOP   = 2'h2;

  // Diagnostics
  localparam logic [31:0] CLEAR_STROKE_MASK = 32'h0000_0100;
  localparam logic [31:0] LIMIT_RST         = 32'hffff_ffff;
  localparam logic [7:0]  PRIO_REPORT       = 8'h01;
  localparam int DIAG_PRIO = 0;
  localparam int DIAG_SIG  = 8;
  localparam logic [8:0] DIAG_RST = 9'h000;

  // Interrupt status bits
  localparam int INT_FAULT  = 0;
  localparam int INT_STROKE = 1;
  localparam int INT_AUX    = 2;
  localparam int INT_WIDTH  = 3;

  // Linked output block view of this transducer
  typedef struct packed {
    logic [1:0] boundCount;
    logic       forceBound;
    logic       spBad;
    logic       casFault;
    logic [1:0] setpoint;
  } vfsc_link_t;

  // Last end position reached by the valve
  typedef enum logic [1:0] {
    END_UNKNOWN,
    END_CLOSED,
    END_OPEN
  } vfsc_end_t;

endpackage

// File: src/vfsc_valve_fault.sv
// Summary of operation
// - Bad channel binding forces fault state
// - Bad setpoint quality forces fault state
// - Output block on force channel forces fault
// - Fault action select drives valve
// - Out-of-service action select drives valve
// - Preset option uses fault preset position
// - Cascade fault-active leaves output block deciding
// - Output block out of service uses transducer selects
// - Working setpoint substatus shows fault active
// - Aux fault lights LED, override, alarm, error
// - Force command flags fault, error, override
// - Diagnostics run only in automatic mode
// - Count each end-to-end valve stroke
// - Alarm when total exceeds limit
// - Report alarm only at priority one
// - Zero total by write or clear mask
// - Signal select bit eight, when set, drives maskable signal
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module vfsc_valve_fault
  import vfsc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire vfsc_link_t  linkIn,
  input  wire logic        auxPinOne,
  input  wire logic        auxPinTwo,
  input  wire logic        endClosedPin,
  input  wire logic        endOpenPin,
  output logic             valveOutputZero,
  output logic             valveOutputOne,
  output logic             auxLedOne,
  output logic             auxLedTwo,
  output logic             tbLocalOverride,
  output logic             doLocalOverride,
  output logic             faultStateFlag,
  output logic             blockErrFault,
  output logic             devFaultAlarm,
  output logic             wspFaultActive,
  output logic             strokeAlarmReport,
  output logic             maskableSignal,
  output logic             irq
);

  // Software registers
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [5:0]            actSel;
  logic [31:0]           strokeTotal;
  logic [31:0]           strokeLimit;
  logic [8:0]            diagCfg;
  logic [INT_WIDTH-1:0]  intStat;
  logic [INT_WIDTH-1:0]  intMask;

  // Pin synchronisers, first stage read only by second
  logic [3:0] pinMeta;
  logic [3:0] pinSync;

  // Block state
  logic [1:0] workSp;
  logic       tbFault;
  logic       auxFault;
  logic       strokeAlarm;
  vfsc_end_t  lastEnd;

  // Next values
  logic [1:0]           next_workSp;
  logic [31:0]          next_total;
  logic [INT_WIDTH-1:0] next_intStat;
  logic [31:0]          next_prdata;

  // Bus decode
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrDone     = accessDone & pwrite;
  wire rdDone     = accessDone & ~pwrite;
  wire hitCtrl    = paddr == ADDR_CTRL;
  wire hitActSel  = paddr == ADDR_ACTSEL;
  wire hitTotal   = paddr == ADDR_TOTAL;
  wire hitLimit   = paddr == ADDR_LIMIT;
  wire hitClear   = paddr == ADDR_CLEAR;
  wire hitDiag    = paddr == ADDR_DIAG;
  wire hitStatus  = paddr == ADDR_STATUS;
  wire hitIntStat = paddr == ADDR_INTSTAT;
  wire hitIntMask = paddr == ADDR_INTMASK;
  wire hitAny     = hitCtrl | hitActSel | hitTotal | hitLimit | hitClear
                  | hitDiag | hitStatus | hitIntStat | hitIntMask;

  // Synchronised pin levels
  wire auxOne    = pinSync[0];
  wire auxTwo    = pinSync[1];
  wire atClosed  = pinSync[2];
  wire atOpen    = pinSync[3];

  // Control fields
  wire tbOos     = ctrl[CTRL_OOS];
  wire diagAuto  = ctrl[CTRL_DIAG_AUTO];
  wire forceCmd  = ctrl[CTRL_FORCE];
  wire chanUsed  = ctrl[CTRL_CHAN_USED];
  wire [1:0] faultSel  = actSel[SEL_FAULT +: 2];
  wire [1:0] oosSel    = actSel[SEL_OOS +: 2];
  wire [1:0] presetPos = actSel[SEL_PRESET +: 2];

  // Fault causes, re-evaluated every cycle so the state clears itself
  wire cfgFault   = (linkIn.boundCount >= 2'h2)
                  | ((linkIn.boundCount == 2'h0) & chanUsed);
  wire qualFault  = linkIn.spBad;
  wire forceFault = linkIn.forceBound;
  wire auxHit     = (auxOne & ctrl[CTRL_AUX_INPUT_ONE_ROUTE])
                  | (auxTwo & ctrl[CTRL_AUX_INPUT_TWO_ROUTE]);
  wire anyFault   = cfgFault | qualFault | forceFault | auxHit;

  // Cascade fault-active is handled by the output block itself,
  // so it never enters the transducer fault path
  wire casOwnFault = linkIn.casFault & ~linkIn.spBad;

  // Resolve one action select into a position
  function automatic logic [1:0] resolve(
    input logic [1:0] sel,
    input logic [1:0] preset,
    input logic [1:0] last
  );
    logic [1:0] pos;
    pos = last;
    unique case (sel)
      ACT_HOLD:   pos = last;
      ACT_CLOSE:  pos = POS_CLOSE;
      ACT_OPEN:   pos = POS_OPEN;
      ACT_PRESET: pos = preset;
    endcase
    return pos;
  endfunction

  // Working setpoint source, out of service ahead of fault
  always_comb
  begin
    if (tbOos)
      next_workSp = resolve(oosSel, presetPos, workSp);
    else if (anyFault)
      next_workSp = resolve(faultSel, presetPos, workSp);
    else
      next_workSp = linkIn.setpoint;
  end

  // Stroke detection: one count per arrival at the opposite end
  wire diagOn      = diagAuto;
  wire strokeDone  = diagOn & (((lastEnd == END_CLOSED) & atOpen & ~atClosed)
                   | ((lastEnd == END_OPEN) & atClosed & ~atOpen));
  wire clrByWrite  = wrDone & hitTotal & (pwdata == 32'h0000_0000);
  wire clrByWord   = wrDone & hitClear
                   & ((pwdata & CLEAR_STROKE_MASK) != 32'h0000_0000);
  wire loadTotal   = wrDone & hitTotal;
  wire alarmNow    = strokeTotal > strokeLimit;

  // Total update; an increment in a clearing cycle survives as one
  always_comb
  begin
    if (clrByWrite | clrByWord)
      next_total = strokeDone ? 32'h0000_0001 : 32'h0000_0000;
    else if (loadTotal)
      next_total = pwdata;
    else if (strokeDone)
      next_total = strokeTotal + 32'h0000_0001;
    else
      next_total = strokeTotal;
  end

  // Sticky events; set wins, and a read clears only the bits it reported,
  // so an event landing on the setup edge is never lost
  wire faultRise  = anyFault & ~tbFault;
  wire alarmRise  = alarmNow & ~strokeAlarm;
  wire auxRise    = auxHit & ~auxFault;
  wire [INT_WIDTH-1:0] intSet = {auxRise, alarmRise, faultRise};
  wire intClr = rdDone & hitIntStat;

  always_comb
  begin
    next_intStat = intClr ? ((intStat & ~prdata[INT_WIDTH-1:0]) | intSet) : (intStat | intSet);
  end

  // Read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hitCtrl)
      next_prdata[CTRL_WIDTH-1:0] = ctrl;
    if (hitActSel)
      next_prdata[5:0] = actSel;
    if (hitTotal)
      next_prdata = strokeTotal;
    if (hitLimit)
      next_prdata = strokeLimit;
    if (hitDiag)
      next_prdata[8:0] = diagCfg;
    if (hitStatus)
      next_prdata[7:0] = {workSp, strokeAlarm, auxFault,
                          forceFault, qualFault, cfgFault, tbFault};
    if (hitIntStat)
      next_prdata[INT_WIDTH-1:0] = intStat;
    if (hitIntMask)
      next_prdata[INT_WIDTH-1:0] = intMask;
  end

  // Pin synchronisers
  always_ff @(posedge clock)
  begin
    pinMeta <= {endOpenPin, endClosedPin, auxPinTwo, auxPinOne};
    pinSync <= pinMeta;
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setupPhase;
      pslverr <= setupPhase & ~hitAny;
      prdata  <= setupPhase ? next_prdata : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl        <= CTRL_RST;
      actSel      <= ACTSEL_RST;
      strokeLimit <= LIMIT_RST;
      diagCfg     <= DIAG_RST;
      intMask     <= '0;
    end
    else
    begin
      if (wrDone & hitCtrl)
        ctrl <= pwdata[CTRL_WIDTH-1:0];
      if (wrDone & hitActSel)
        actSel <= pwdata[5:0];
      if (wrDone & hitLimit)
        strokeLimit <= pwdata;
      if (wrDone & hitDiag)
        diagCfg <= pwdata[8:0];
      if (wrDone & hitIntMask)
        intMask <= pwdata[INT_WIDTH-1:0];
    end
  end

  // Core state
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      workSp      <= POS_CLOSE;
      tbFault     <= 1'b0;
      auxFault    <= 1'b0;
      strokeAlarm <= 1'b0;
      strokeTotal <= 32'h0000_0000;
      intStat     <= '0;
    end
    else
    begin
      workSp      <= next_workSp;
      tbFault     <= anyFault;
      auxFault    <= auxHit;
      strokeAlarm <= alarmNow;
      strokeTotal <= next_total;
      intStat     <= next_intStat;
    end
  end

  // End position tracker
  always_ff @(posedge clock)
  begin
    if (srst)
      lastEnd <= END_UNKNOWN;
    else if (atClosed & ~atOpen)
      lastEnd <= END_CLOSED;
    else if (atOpen & ~atClosed)
      lastEnd <= END_OPEN;
  end

  // Valve drive: open on output zero, close on output one, stop neither
  wire drvZero = next_workSp == POS_OPEN;
  wire drvOne  = next_workSp == POS_CLOSE;

  // Registered outputs
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      valveOutputZero   <= 1'b0;
      valveOutputOne    <= 1'b0;
      auxLedOne         <= 1'b0;
      auxLedTwo         <= 1'b0;
      tbLocalOverride   <= 1'b0;
      doLocalOverride   <= 1'b0;
      faultStateFlag    <= 1'b0;
      blockErrFault     <= 1'b0;
      devFaultAlarm     <= 1'b0;
      wspFaultActive    <= 1'b0;
      strokeAlarmReport <= 1'b0;
      maskableSignal    <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      valveOutputZero   <= drvZero;
      valveOutputOne    <= drvOne;
      auxLedOne         <= auxOne;
      auxLedTwo         <= auxTwo;
      tbLocalOverride   <= anyFault & ~tbOos;
      doLocalOverride   <= casOwnFault | forceCmd;
      faultStateFlag    <= forceCmd | auxHit;
      blockErrFault     <= forceCmd | auxHit;
      devFaultAlarm     <= anyFault | forceCmd;
      wspFaultActive    <= anyFault;
      strokeAlarmReport <= alarmNow & (diagCfg[DIAG_PRIO +: 8] == PRIO_REPORT);
      maskableSignal    <= alarmNow & diagCfg[DIAG_SIG];
      irq               <= |(next_intStat & intMask);
    end
  end

  // Checks
  chk_fault_select: assert property (@(posedge clock) disable iff (srst)
    (!tbOos && anyFault && faultSel == ACT_OPEN) |=> valveOutputZero && !valveOutputOne)
    else $error("fault open select not applied");

  chk_oos_priority: assert property (@(posedge clock) disable iff (srst)
    (tbOos && oosSel == ACT_CLOSE) |=> valveOutputOne && !valveOutputZero)
    else $error("out of service close select not applied");

  chk_preset_stop: assert property (@(posedge clock) disable iff (srst)
    (tbOos && oosSel == ACT_PRESET && presetPos == POS_STOP)
      |=> !valveOutputZero && !valveOutputOne)
    else $error("preset stop not applied");

  chk_bad_quality: assert property (@(posedge clock) disable iff (srst)
    linkIn.spBad |=> wspFaultActive && tbFault)
    else $error("bad setpoint quality did not fault");

  chk_fault_exit: assert property (@(posedge clock) disable iff (srst)
    (tbFault && !anyFault) |=> !wspFaultActive)
    else $error("fault state not released");

  chk_cas_own: assert property (@(posedge clock) disable iff (srst)
    (linkIn.casFault && !linkIn.spBad && !anyFault && !tbOos)
      |=> doLocalOverride && workSp == $past(linkIn.setpoint))
    else $error("cascade fault handled by transducer");

  chk_force_cmd: assert property (@(posedge clock) disable iff (srst)
    forceCmd |=> faultStateFlag && blockErrFault && doLocalOverride)
    else $error("force command not reflected");

  chk_stroke_inc: assert property (@(posedge clock) disable iff (srst)
    (strokeDone && !wrDone) |=> strokeTotal == $past(strokeTotal) + 32'h0000_0001)
    else $error("stroke not counted");

  chk_diag_auto: assert property (@(posedge clock) disable iff (srst)
    (!diagAuto && !wrDone) |=> $stable(strokeTotal))
    else $error("counter moved outside automatic mode");

  chk_clear_word: assert property (@(posedge clock) disable iff (srst)
    (clrByWord && !strokeDone) |=> strokeTotal == 32'h0000_0000)
    else $error("clear word did not zero total");

  chk_alarm_report: assert property (@(posedge clock) disable iff (srst)
    strokeAlarmReport |-> $past(alarmNow) && $past(diagCfg[DIAG_PRIO +: 8]) == PRIO_REPORT)
    else $error("alarm reported at wrong priority");

  chk_mask_signal: assert property (@(posedge clock) disable iff (srst)
    (alarmNow && diagCfg[DIAG_SIG]) |=> maskableSignal)
    else $error("maskable signal missing");

  chk_cfg_fault: assert property (@(posedge clock) disable iff (srst)
    (linkIn.boundCount == 2'h2) |=> wspFaultActive)
    else $error("double binding did not fault");

  chk_aux_fault: assert property (@(posedge clock) disable iff (srst)
    auxHit |=> auxFault && devFaultAlarm && blockErrFault)
    else $error("aux fault indication missing");

endmodule

// File: sim/vfsc_valve_model.sv
`timescale 1ns/1ps
// Actuator with two end switches, moved by the valve outputs
module vfsc_valve_model
  import vfsc_pkg::*;
#(
  parameter int TRAVEL = 8
)
(
  input  wire logic clock,
  input  wire logic openCmd,
  input  wire logic closeCmd,
  output logic      endClosedPin,
  output logic      endOpenPin
);
  int pos = TRAVEL / 2;

  // A full stroke takes TRAVEL cycles; both or no command stops the stem
  always @(posedge clock)
  begin
    if (openCmd && !closeCmd && pos < TRAVEL)
      pos <= pos + 1;
    else if (closeCmd && !openCmd && pos > 0)
      pos <= pos - 1;
  end

  // Switches make only at the travel ends, mid-travel both read open
  assign endClosedPin = (pos == 0);
  assign endOpenPin   = (pos == TRAVEL);
endmodule

// File: sim/valve_fault_state_control_tb_top.sv
`timescale 1ns/1ps
module valve_fault_state_control_tb_top
  import vfsc_pkg::*;
;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  vfsc_link_t  link;
  logic        auxPinOne, auxPinTwo, valveOutputZero, valveOutputOne, auxLedOne, auxLedTwo;
  logic        tbLocalOverride, doLocalOverride, faultStateFlag, blockErrFault, devFaultAlarm;
  logic        wspFaultActive, strokeAlarmReport, maskableSignal, irq;
  wire         endClosedPin, endOpenPin;
  int          errCount, totalChecks;
  localparam logic [7:0]  RADDR [6] = '{ADDR_CTRL, ADDR_ACTSEL, ADDR_TOTAL, ADDR_LIMIT, ADDR_DIAG, ADDR_INTMASK};
  localparam logic [31:0] RVAL [6]  = '{32'(CTRL_RST), 32'(ACTSEL_RST), 32'h0, LIMIT_RST, 32'(DIAG_RST), 32'h0};
  localparam logic [5:0]  FSEL [5]  = '{6'h01, 6'h02, 6'h03, 6'h13, 6'h23};
  localparam logic [1:0]  FPOS [5]  = '{POS_CLOSE, POS_OPEN, POS_CLOSE, POS_OPEN, POS_STOP};

  vfsc_valve_fault uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkIn(link),
    .auxPinOne(auxPinOne), .auxPinTwo(auxPinTwo), .endClosedPin(endClosedPin), .endOpenPin(endOpenPin),
    .valveOutputZero(valveOutputZero), .valveOutputOne(valveOutputOne), .auxLedOne(auxLedOne),
    .auxLedTwo(auxLedTwo), .tbLocalOverride(tbLocalOverride), .doLocalOverride(doLocalOverride),
    .faultStateFlag(faultStateFlag), .blockErrFault(blockErrFault), .devFaultAlarm(devFaultAlarm),
    .wspFaultActive(wspFaultActive), .strokeAlarmReport(strokeAlarmReport),
    .maskableSignal(maskableSignal), .irq(irq));

  vfsc_valve_model valve (.clock(clock), .openCmd(valveOutputZero), .closeCmd(valveOutputOne),
    .endClosedPin(endClosedPin), .endOpenPin(endOpenPin));

  always #2.5 clock = ~clock;

  // Transfer starts one edge in, so back-to-back calls never drive twice in a step
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rdata, output logic slverr);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b1, a, wd, d, e);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb_xfer(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk_word(input logic [31:0] act, input logic [31:0] exp);
    totalChecks++;
    if (act !== exp)
    begin
      errCount++;
      $display("[ERR] %0t word %h expected %h", $time, act, exp);
    end
  endtask

  task automatic chk_bit(input logic act, input logic exp);
    chk_word({31'h0, act}, {31'h0, exp});
  endtask

  // Open drives output zero, close output one, stop neither
  task automatic chk_valve(input logic [1:0] pos);
    chk_bit(valveOutputZero, pos == POS_OPEN);
    chk_bit(valveOutputOne, pos == POS_CLOSE);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    #50000;
    errCount++;
    $display("[ERR] %0t timeout", $time);
    finishTest();
  end

  initial
  begin
    clock = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    link = '{2'h1, 1'b0, 1'b0, 1'b0, POS_STOP};
    auxPinOne = 1'b0;
    auxPinTwo = 1'b0;
    errCount = 0;
    totalChecks = 0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    wait_cyc(4);
    // Reset values, then an unmapped word
    for (int i = 0; i < 6; i++)
    begin
      apb_xfer(1'b0, RADDR[i], 32'h0, rd, err);
      chk_word(rd, RVAL[i]);
      chk_bit(err, 1'b0);
    end
    apb_xfer(1'b0, 8'h24, 32'h0, rd, err);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0);
    // Every close/open/preset action under bad quality, then recovery
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(ADDR_ACTSEL, 32'(FSEL[i]));
      link.spBad <= 1'b1;
      wait_cyc(3);
      chk_valve(FPOS[i]);
      chk_bit(wspFaultActive, 1'b1);
      link.spBad <= 1'b0;
      wait_cyc(3);
      chk_bit(wspFaultActive, 1'b0);
      chk_valve(POS_STOP);
    end
    // Hold keeps the setpoint from before the fault
    link.setpoint <= POS_OPEN;
    wr_reg(ADDR_ACTSEL, 32'h0);
    link.spBad <= 1'b1;
    wait_cyc(2);
    link.setpoint <= POS_CLOSE;
    wait_cyc(3);
    chk_valve(POS_OPEN);
    link.spBad <= 1'b0;
    wait_cyc(3);
    chk_valve(POS_CLOSE);
    // Channel binding mistakes and the force channel
    link.boundCount <= 2'h2;
    wait_cyc(3);
    chk_bit(devFaultAlarm, 1'b1);
    link.boundCount <= 2'h0;
    wait_cyc(3);
    chk_bit(wspFaultActive, 1'b1);
    link.boundCount <= 2'h1;
    link.forceBound <= 1'b1;
    wait_cyc(3);
    chk_bit(wspFaultActive, 1'b1);
    link.forceBound <= 1'b0;
    wait_cyc(3);
    chk_bit(devFaultAlarm, 1'b0);
    // Cascade fault: output block decides, then its own out of service
    wr_reg(ADDR_ACTSEL, 32'h01);
    link.casFault <= 1'b1;
    link.setpoint <= POS_OPEN;
    wait_cyc(3);
    chk_bit(doLocalOverride, 1'b1);
    chk_bit(wspFaultActive, 1'b0);
    chk_valve(POS_OPEN);
    link.spBad <= 1'b1;
    wait_cyc(3);
    chk_valve(POS_CLOSE);
    chk_bit(doLocalOverride, 1'b0);
    // Out of service wins over fault
    wr_reg(ADDR_ACTSEL, 32'h09);
    wr_reg(ADDR_CTRL, 32'h0b);
    wait_cyc(3);
    chk_valve(POS_OPEN);
    chk_bit(tbLocalOverride, 1'b0);
    wr_reg(ADDR_ACTSEL, 32'h06);
    wait_cyc(3);
    chk_valve(POS_CLOSE);
    wr_reg(ADDR_ACTSEL, 32'h2c);
    wait_cyc(3);
    chk_valve(POS_STOP);
    link.spBad <= 1'b0;
    link.casFault <= 1'b0;
    // Aux input routed to the fault path, with its interrupt
    rd_reg(ADDR_INTSTAT, rd);
    wr_reg(ADDR_INTMASK, 32'h4);
    wr_reg(ADDR_ACTSEL, 32'h02);
    wr_reg(ADDR_CTRL, 32'h1a);
    link.setpoint <= POS_CLOSE;
    auxPinOne <= 1'b1;
    auxPinTwo <= 1'b1;
    wait_cyc(6);
    chk_bit(auxLedOne, 1'b1);
    chk_bit(auxLedTwo, 1'b1);
    chk_valve(POS_OPEN);
    chk_bit(tbLocalOverride, 1'b1);
    chk_bit(devFaultAlarm, 1'b1);
    chk_bit(blockErrFault, 1'b1);
    chk_bit(irq, 1'b1);
    rd_reg(ADDR_INTSTAT, rd);
    chk_word(rd & 32'h4, 32'h4);
    auxPinOne <= 1'b0;
    wait_cyc(6);
    chk_bit(irq, 1'b0);
    chk_bit(devFaultAlarm, 1'b0);
    auxPinTwo <= 1'b0;
    // Force command from software
    wr_reg(ADDR_CTRL, 32'h0e);
    wait_cyc(2);
    chk_bit(faultStateFlag, 1'b1);
    chk_bit(blockErrFault, 1'b1);
    chk_bit(doLocalOverride, 1'b1);
    wr_reg(ADDR_CTRL, 32'h0a);
    wait_cyc(20);
    chk_bit(faultStateFlag, 1'b0);
    // Stroke total, limit boundary, priority and signal select
    wr_reg(ADDR_TOTAL, 32'h5);
    rd_reg(ADDR_TOTAL, rd);
    chk_word(rd, 32'h5);
    wr_reg(ADDR_TOTAL, 32'h0);
    wr_reg(ADDR_LIMIT, 32'h1);
    wr_reg(ADDR_DIAG, 32'h101);
    wr_reg(ADDR_INTMASK, 32'h2);
    link.setpoint <= POS_OPEN;
    wait_cyc(20);
    rd_reg(ADDR_TOTAL, rd);
    chk_word(rd, 32'h1);
    chk_bit(strokeAlarmReport, 1'b0);
    link.setpoint <= POS_CLOSE;
    wait_cyc(20);
    chk_bit(strokeAlarmReport, 1'b1);
    chk_bit(maskableSignal, 1'b1);
    chk_bit(irq, 1'b1);
    wr_reg(ADDR_DIAG, 32'h102);
    wait_cyc(2);
    chk_bit(strokeAlarmReport, 1'b0);
    chk_bit(maskableSignal, 1'b1);
    wr_reg(ADDR_DIAG, 32'h002);
    wait_cyc(2);
    chk_bit(maskableSignal, 1'b0);
    wr_reg(ADDR_CLEAR, 32'hff);
    rd_reg(ADDR_TOTAL, rd);
    chk_word(rd, 32'h2);
    wr_reg(ADDR_CLEAR, CLEAR_STROKE_MASK);
    rd_reg(ADDR_TOTAL, rd);
    chk_word(rd, 32'h0);
    // Diagnostics out of automatic do not count
    wr_reg(ADDR_CTRL, 32'h08);
    link.setpoint <= POS_OPEN;
    wait_cyc(20);
    rd_reg(ADDR_TOTAL, rd);
    chk_word(rd, 32'h0);
    finishTest();
  end
endmodule
